// [hw/stp_pkg.sv]
// stp_pkg: constants and types for the slew rate / timeout pulse trigger
// assumes 100 MHz system clock; input samples are digital codes per cycle
package stp_pkg;

	// sample and timer widths, channel count
	localparam int SMP_W = 12;
	localparam int TIM_W = 24;
	localparam int NCH   = 4;

	// clock period in ps
	localparam int CLK_PS = 10000;

	// least resolvable transit, in ps, and as cycles (rounded up, >= 1)
	localparam int MIN_TRANSIT_PS  = 600;
	localparam int MIN_TRANSIT_CYC =
		(MIN_TRANSIT_PS + CLK_PS - 1) / CLK_PS;

	// least pulse width the source must hold, in ps
	localparam int MIN_PULSE_PS  = 7500;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PS - 1) / CLK_PS;

	// logic family presets, codes on the sample scale
	localparam logic [11:0] TTL_UPPER = 12'h8c0;
	localparam logic [11:0] TTL_LOWER = 12'h840;
	localparam logic [11:0] ECL_UPPER = 12'h780;
	localparam logic [11:0] ECL_LOWER = 12'h700;
	localparam logic [11:0] TTL_LEVEL = 12'h88c;
	localparam logic [11:0] ECL_LEVEL = 12'h72c;

	// reset values
	localparam logic [11:0] RST_UPPER = 12'h900;
	localparam logic [11:0] RST_LOWER = 12'h700;
	localparam logic [11:0] RST_LEVEL = 12'h800;

	// half-level peak search length in cycles
	localparam int PEAK_WIN_CYC = 1024;

	// trigger class
	typedef enum logic [1:0] {
		STP_CLS_SLEW = 2'h0,
		STP_CLS_TMO  = 2'h1
	} stp_class_t;

	// polarity: positive / stays high, negative / stays low, either
	typedef enum logic [1:0] {
		STP_POL_POS = 2'h0,
		STP_POL_NEG = 2'h1,
		STP_POL_ANY = 2'h2
	} stp_pol_t;

	// threshold preset request
	typedef enum logic [1:0] {
		STP_PRE_NONE = 2'h0,
		STP_PRE_TTL  = 2'h1,
		STP_PRE_ECL  = 2'h2
	} stp_preset_t;

	// slew edge tracker states, one-hot
	typedef enum logic [3:0] {
		STP_SL_IDLE = 4'h1,
		STP_SL_UP   = 4'h2,
		STP_SL_DN   = 4'h4,
		STP_SL_WAIT = 4'h8
	} stp_slew_st_t;

endpackage

// [hw/stp_cmp_if.sv]
// stp_cmp_if: comparator results shared between the trigger modules
// assumes one sample per system clock
`timescale 1ns/100ps
interface stp_cmp_if;
	logic above_upper;
	logic below_lower;
	logic above_level;
	logic [11:0] sample;

	modport src (
		output above_upper,
		output below_lower,
		output above_level,
		output sample
	);
	modport dst (
		input above_upper,
		input below_lower,
		input above_level,
		input sample
	);
endinterface

// [hw/stp_cmp.sv]
// stp_cmp: source channel mux and threshold comparators
// assumes channel samples synchronous to i_clk_sys
`timescale 1ns/100ps
module stp_cmp (
	// clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_nrst,
	// channel samples and selection
	input  wire logic [4*12-1:0]    i_ch_data,
	input  wire logic [1:0]         i_src_sel,
	// thresholds
	input  wire logic [11:0]        i_upper,
	input  wire logic [11:0]        i_lower,
	input  wire logic [11:0]        i_level,
	// comparator results
	stp_cmp_if.src                  cmp
);

	logic [11:0] smp_reg;

	// registered so every class sees the same sample
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			smp_reg <= 12'h000;
		end else begin
			smp_reg <= i_ch_data[i_src_sel*12 +: 12];
		end
	end

	assign cmp.sample      = smp_reg;
	assign cmp.above_upper = smp_reg >= i_upper;
	assign cmp.below_lower = smp_reg <= i_lower;
	assign cmp.above_level = smp_reg > i_level;

endmodule

// [hw/stp_tmo.sv]
// stp_tmo: timeout qualifier on the level comparator
// assumes comparator results valid each cycle
`timescale 1ns/100ps
module stp_tmo (
	// clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_nrst,
	// setup
	input  wire logic               i_en,
	input  wire logic [1:0]         i_pol,
	input  wire logic [23:0]        i_timeout,
	// comparator input
	stp_cmp_if.dst                  cmp,
	// trigger
	output logic                    o_trig
);

	logic        prev_reg;
	logic [23:0] cnt_reg;
	logic        fired_reg;
	logic        side_ok;

	// polarity chooses which side may time out
	always_comb begin
		case (stp_pkg::stp_pol_t'(i_pol))
			stp_pkg::STP_POL_POS: side_ok = cmp.above_level;
			stp_pkg::STP_POL_NEG: side_ok = !cmp.above_level;
			stp_pkg::STP_POL_ANY: side_ok = 1'b1;
			default:              side_ok = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_reg  <= 1'b0;
			cnt_reg   <= 24'h000000;
			fired_reg <= 1'b0;
			o_trig    <= 1'b0;
		end else begin
			prev_reg <= cmp.above_level;
			o_trig   <= 1'b0;
			// any level crossing restarts the stay
			if (!i_en || prev_reg != cmp.above_level) begin
				cnt_reg   <= 24'h000000;
				fired_reg <= 1'b0;
			end else if (cnt_reg != 24'hffffff) begin
				cnt_reg <= cnt_reg + 24'h000001;
			end
			// one trigger per uninterrupted stay
			if (i_en && prev_reg == cmp.above_level && side_ok &&
			    !fired_reg && cnt_reg >= i_timeout) begin
				o_trig    <= 1'b1;
				fired_reg <= 1'b1;
			end
		end
	end

endmodule

// [hw/stp_trig.sv]
// stp_trig: slew rate and timeout pulse trigger, top level
// assumes four synchronous sample streams and front-panel settings as ports
//
// Overview of operation
// - slew class triggers on edges faster or slower than the slew setting
// - positive polarity: lower threshold crossed first, then upper
// - negative polarity: upper threshold crossed first, then lower
// - either polarity: either threshold first, then the opposite one
// - one of four channels is the source for every class
// - slew setting is threshold difference over delta time, no direct input
// - a selector picks faster-than or slower-than triggering
// - transits of 600 ps or less need not be detected
// - trigger point is the crossing of the last threshold
// - timeout stays-high fires after staying above level past timeout
// - timeout stays-low fires after staying below level past timeout
// - timeout either fires after staying on any one side past timeout
// - timeout duration is programmable
// - set-to-half measures peaks and sets level to their midpoint
// - presets load TTL or ECL values into the slew thresholds
`timescale 1ns/100ps
module stp_trig (
	// clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_nrst,
	// channel samples, channel n in bits n*12 +: 12
	input  wire logic [4*12-1:0]    i_ch_data,
	input  wire logic [1:0]         i_src_sel,
	// class and polarity
	input  wire logic [1:0]         i_class,
	input  wire logic [1:0]         i_pol,
	input  wire logic               i_slower,
	// threshold and level programming
	input  wire logic               i_upper_wr,
	input  wire logic [11:0]        i_upper_val,
	input  wire logic               i_lower_wr,
	input  wire logic [11:0]        i_lower_val,
	input  wire logic               i_level_wr,
	input  wire logic [11:0]        i_level_val,
	input  wire logic [1:0]         i_preset,
	input  wire logic               i_half_req,
	// time settings in cycles
	input  wire logic [23:0]        i_delta_time,
	input  wire logic [23:0]        i_timeout,
	// trigger output
	output logic                    o_trig,
	// settings readback
	output logic [11:0]             o_upper,
	output logic [11:0]             o_lower,
	output logic [11:0]             o_level,
	output logic [11:0]             o_slew_dv,
	output logic [23:0]             o_slew_dt,
	output logic [23:0]             o_transit,
	output logic                    o_half_busy
);

	stp_cmp_if cmp ();

	logic [11:0]           upper_reg;
	logic [11:0]           lower_reg;
	logic [11:0]           level_reg;
	stp_pkg::stp_slew_st_t st_reg;
	logic [23:0]           tcnt_reg;
	logic                  slew_trig_reg;
	logic [23:0]           transit_reg;
	logic                  first_up_reg;
	logic                  half_busy_reg;
	logic [10:0]           win_reg;
	logic [11:0]           pk_hi_reg;
	logic [11:0]           pk_lo_reg;
	logic                  tmo_trig;
	logic                  slew_en;
	logic                  tmo_en;
	logic                  rate_ok;

	assign slew_en = stp_pkg::stp_class_t'(i_class) == stp_pkg::STP_CLS_SLEW;
	assign tmo_en  = stp_pkg::stp_class_t'(i_class) == stp_pkg::STP_CLS_TMO;

	// midpoint of two codes without overflow
	function automatic logic [11:0] mid(input logic [11:0] a,
	                                    input logic [11:0] b);
		logic [12:0] s;
		s   = {1'b0, a} + {1'b0, b};
		mid = s[12:1];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// comparators and timeout qualifier

	stp_cmp u_cmp (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_ch_data (i_ch_data),
		.i_src_sel (i_src_sel),
		.i_upper   (upper_reg),
		.i_lower   (lower_reg),
		.i_level   (level_reg),
		.cmp       (cmp.src)
	);

	stp_tmo u_tmo (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_en      (tmo_en),
		.i_pol     (i_pol),
		.i_timeout (i_timeout),
		.cmp       (cmp.dst),
		.o_trig    (tmo_trig)
	);

	////////////////////////////////////////////////////////////////////////
	// thresholds and level

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			upper_reg <= stp_pkg::RST_UPPER;
			lower_reg <= stp_pkg::RST_LOWER;
		end else begin
			case (stp_pkg::stp_preset_t'(i_preset))
				stp_pkg::STP_PRE_TTL: begin
					upper_reg <= stp_pkg::TTL_UPPER;
					lower_reg <= stp_pkg::TTL_LOWER;
				end
				stp_pkg::STP_PRE_ECL: begin
					upper_reg <= stp_pkg::ECL_UPPER;
					lower_reg <= stp_pkg::ECL_LOWER;
				end
				default: begin
					if (i_upper_wr) begin
						upper_reg <= i_upper_val;
					end
					if (i_lower_wr) begin
						lower_reg <= i_lower_val;
					end
				end
			endcase
		end
	end

	// level: direct write, family preset, or half-peak search result
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			level_reg <= stp_pkg::RST_LEVEL;
		end else if (half_busy_reg && win_reg == 11'h000) begin
			level_reg <= mid(pk_hi_reg, pk_lo_reg);
		end else if (stp_pkg::stp_preset_t'(i_preset) ==
		             stp_pkg::STP_PRE_TTL) begin
			level_reg <= stp_pkg::TTL_LEVEL;
		end else if (stp_pkg::stp_preset_t'(i_preset) ==
		             stp_pkg::STP_PRE_ECL) begin
			level_reg <= stp_pkg::ECL_LEVEL;
		end else if (i_level_wr) begin
			level_reg <= i_level_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// set-to-half peak search

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			half_busy_reg <= 1'b0;
			win_reg       <= 11'h000;
			pk_hi_reg     <= 12'h000;
			pk_lo_reg     <= 12'hfff;
		end else if (!half_busy_reg) begin
			if (i_half_req) begin
				half_busy_reg <= 1'b1;
				win_reg       <= 11'(stp_pkg::PEAK_WIN_CYC);
				pk_hi_reg     <= 12'h000;
				pk_lo_reg     <= 12'hfff;
			end
		end else begin
			// peaks tracked over a fixed window, long enough for slow input
			if (cmp.sample > pk_hi_reg) begin
				pk_hi_reg <= cmp.sample;
			end
			if (cmp.sample < pk_lo_reg) begin
				pk_lo_reg <= cmp.sample;
			end
			if (win_reg == 11'h000) begin
				half_busy_reg <= 1'b0;
			end else begin
				win_reg <= win_reg - 11'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slew edge tracker

	// slew setting is only the pair (dv, dt); compare by time at fixed dv
	assign rate_ok = i_slower ? (tcnt_reg > i_delta_time)
	                          : (tcnt_reg < i_delta_time);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg        <= stp_pkg::STP_SL_IDLE;
			tcnt_reg      <= 24'h000000;
			slew_trig_reg <= 1'b0;
			transit_reg   <= 24'h000000;
			first_up_reg  <= 1'b0;
		end else begin
			slew_trig_reg <= 1'b0;
			if (tcnt_reg != 24'hffffff) begin
				tcnt_reg <= tcnt_reg + 24'h000001;
			end
			case (st_reg)
				stp_pkg::STP_SL_IDLE: begin
					// wait for the input to settle outside the band
					if (slew_en && cmp.below_lower) begin
						st_reg <= stp_pkg::STP_SL_UP;
					end else if (slew_en && cmp.above_upper) begin
						st_reg <= stp_pkg::STP_SL_DN;
					end
					tcnt_reg <= 24'h000000;
				end
				stp_pkg::STP_SL_UP, stp_pkg::STP_SL_DN: begin
					// leaving the start threshold begins the transit
					tcnt_reg <= 24'h000000;
					if (!slew_en) begin
						st_reg <= stp_pkg::STP_SL_IDLE;
					end else if (st_reg == stp_pkg::STP_SL_UP &&
					             !cmp.below_lower) begin
						first_up_reg <= 1'b1;
						st_reg       <= stp_pkg::STP_SL_WAIT;
					end else if (st_reg == stp_pkg::STP_SL_DN &&
					             !cmp.above_upper) begin
						first_up_reg <= 1'b0;
						st_reg       <= stp_pkg::STP_SL_WAIT;
					end
				end
				stp_pkg::STP_SL_WAIT: begin
					if (!slew_en) begin
						st_reg <= stp_pkg::STP_SL_IDLE;
					end else if (first_up_reg && cmp.above_upper) begin
						// fire at the last-crossed threshold
						transit_reg   <= tcnt_reg;
						slew_trig_reg <= rate_ok &&
							stp_pkg::stp_pol_t'(i_pol) !=
							stp_pkg::STP_POL_NEG;
						st_reg        <= stp_pkg::STP_SL_DN;
					end else if (!first_up_reg && cmp.below_lower) begin
						transit_reg   <= tcnt_reg;
						slew_trig_reg <= rate_ok &&
							stp_pkg::stp_pol_t'(i_pol) !=
							stp_pkg::STP_POL_POS;
						st_reg        <= stp_pkg::STP_SL_UP;
					end else if (first_up_reg && cmp.below_lower) begin
						// fell back: not an edge, restart
						st_reg <= stp_pkg::STP_SL_UP;
					end else if (!first_up_reg && cmp.above_upper) begin
						st_reg <= stp_pkg::STP_SL_DN;
					end
				end
				default: begin
					st_reg <= stp_pkg::STP_SL_IDLE;
				end
			endcase
		end
	end

	// one sample per 10 ns: sub-cycle transits read as zero count
	// and are only caught as faster-than, which is allowed

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_trig <= 1'b0;
		end else begin
			o_trig <= slew_trig_reg | tmo_trig;
		end
	end

	assign o_upper     = upper_reg;
	assign o_lower     = lower_reg;
	assign o_level     = level_reg;
	assign o_slew_dv   = upper_reg - lower_reg;
	assign o_slew_dt   = i_delta_time;
	assign o_transit   = transit_reg;
	assign o_half_busy = half_busy_reg;

endmodule

// [tb/stp_src_model.sv]
// stp_src_model: analog source seen by the threshold comparators
// assumes inputs change just after the rising clock edge
`timescale 1ns/100ps
module stp_src_model (
	// clock
	input  wire logic        i_clk_sys,
	// waveform control
	input  wire logic [1:0]  i_sel,
	input  wire logic [11:0] i_target,
	input  wire logic [11:0] i_step,
	// channel samples
	output logic      [47:0] o_ch_data
);
	logic [11:0] cur_reg = 12'h600;
	logic        tog_reg = 1'b0;
	////////////////////////////////////////
	// ramp toward target, then hold it as long as commanded
	always_ff @(posedge i_clk_sys) begin
		tog_reg <= !tog_reg;
		if (i_target > cur_reg)
			cur_reg <= (i_target - cur_reg > i_step) ?
				cur_reg + i_step : i_target;
		else if (cur_reg - i_target > i_step)
			cur_reg <= cur_reg - i_step;
		else
			cur_reg <= i_target;
	end
	// unused channels swing rail to rail, so a wrong source shows at once
	always_comb begin
		for (int k = 0; k < 4; k++)
			o_ch_data[k*12 +: 12] = tog_reg ? 12'hfff : 12'h000;
		o_ch_data[i_sel*12 +: 12] = cur_reg;
	end
endmodule

// [tb/stp_trig_checker.sv]
// stp_trig_checker: port-level properties of the pulse trigger
// assumes binding onto stp_trig, a single clock domain
`timescale 1ns/100ps
module stp_trig_checker (
	// clock and reset
	input wire logic        i_clk_sys,
	input wire logic        i_nrst,
	// inputs watched
	input wire logic [47:0] i_ch_data,
	input wire logic [1:0]  i_src_sel,
	input wire logic [1:0]  i_class,
	input wire logic [1:0]  i_pol,
	input wire logic [1:0]  i_preset,
	input wire logic        i_half_req,
	input wire logic        i_upper_wr,
	input wire logic        i_lower_wr,
	input wire logic [23:0] i_timeout,
	// outputs watched
	input wire logic        o_trig,
	input wire logic [11:0] o_upper,
	input wire logic [11:0] o_lower,
	input wire logic [11:0] o_level,
	input wire logic [11:0] o_slew_dv,
	input wire logic        o_half_busy
);
	logic [11:0] sel;
	logic        slw;
	logic        tmo;
	logic        hi_reg;
	logic [23:0] stay_reg;
	logic [10:0] busy_reg;
	assign sel = i_ch_data[i_src_sel*12 +: 12];
	assign slw = i_class == stp_pkg::STP_CLS_SLEW;
	assign tmo = i_class == stp_pkg::STP_CLS_TMO;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////
	// input-side stay length, leads the design count by the sample register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			hi_reg   <= 1'b0;
			stay_reg <= 24'h0;
		end else begin
			hi_reg <= sel > o_level;
			if ((sel > o_level) != hi_reg)
				stay_reg <= 24'h0;
			else if (stay_reg != 24'hffffff)
				stay_reg <= stay_reg + 24'h1;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			busy_reg <= 11'h0;
		else
			busy_reg <= o_half_busy ? busy_reg + 11'h1 : 11'h0;
	end
	////////////////////////////////////////
	trig_pulse_a: assert property (
		o_trig |=> !o_trig) else $error("trigger wider than a cycle");
	slew_dv_a: assert property (
		o_slew_dv == o_upper - o_lower) else $error("slew volts wrong");
	pos_last_a: assert property (
		o_trig && slw && i_pol == stp_pkg::STP_POL_POS |->
		$past(sel, 2) >= o_upper || $past(sel, 3) >= o_upper ||
		$past(sel, 4) >= o_upper) else $error("rise trigger early");
	neg_last_a: assert property (
		o_trig && slw && i_pol == stp_pkg::STP_POL_NEG |->
		$past(sel, 2) <= o_lower || $past(sel, 3) <= o_lower ||
		$past(sel, 4) <= o_lower) else $error("fall trigger early");
	tmo_high_a: assert property (
		o_trig && tmo && i_pol == stp_pkg::STP_POL_POS |->
		$past(sel, 3) > o_level) else $error("stays high side wrong");
	tmo_low_a: assert property (
		o_trig && tmo && i_pol == stp_pkg::STP_POL_NEG |->
		$past(sel, 3) <= o_level) else $error("stays low side wrong");
	tmo_len_a: assert property (
		o_trig && tmo |-> stay_reg >= i_timeout)
		else $error("timeout trigger too soon");
	half_take_a: assert property (
		i_half_req && !o_half_busy |=> o_half_busy)
		else $error("half search not started");
	half_len_a: assert property (
		$fell(o_half_busy) |-> busy_reg inside {[11'd1020:11'd1030]})
		else $error("half search length wrong");
	preset_a: assert property (
		i_preset == stp_pkg::STP_PRE_TTL && !o_half_busy && !i_upper_wr &&
		!i_lower_wr |=> o_upper == stp_pkg::TTL_UPPER &&
		o_lower == stp_pkg::TTL_LOWER) else $error("ttl preset not loaded");
	cov_slew_c: cover property (o_trig && slw);
	cov_tmo_c: cover property (o_trig && tmo);
	cov_half_c: cover property ($fell(o_half_busy));
endmodule
////////////////////////////////////////
bind stp_trig stp_trig_checker u_chk (.i_clk_sys, .i_nrst, .i_ch_data,
	.i_src_sel, .i_class, .i_pol, .i_preset, .i_half_req, .i_upper_wr,
	.i_lower_wr, .i_timeout, .o_trig, .o_upper, .o_lower, .o_level,
	.o_slew_dv, .o_half_busy);

// [tb/testbench.sv]
// testbench: table of trigger cases, then settings, search and reset
// assumes stp_trig, stp_src_model and the bound checker
`timescale 1ns/100ps
module testbench;
	typedef struct {
		logic [1:0]  cls;
		logic [1:0]  pol;
		logic        slw;
		logic [11:0] st;
		logic [11:0] tg;
		logic [11:0] sp;
		int          n;
	} stp_tb_row_t;
	logic        i_clk_sys    = 1'b0;
	logic        i_nrst       = 1'b0;
	logic [47:0] i_ch_data;
	logic [1:0]  i_src_sel    = 2'h0;
	logic [1:0]  i_class      = 2'h3;
	logic [1:0]  i_pol        = 2'h0;
	logic        i_slower     = 1'b0;
	logic        i_upper_wr   = 1'b0;
	logic        i_lower_wr   = 1'b0;
	logic        i_level_wr   = 1'b0;
	logic [11:0] i_upper_val  = 12'h950;
	logic [11:0] i_lower_val  = 12'h650;
	logic [11:0] i_level_val  = 12'h7f0;
	logic [1:0]  i_preset     = 2'h0;
	logic        i_half_req   = 1'b0;
	logic [23:0] i_delta_time = 24'd10;
	logic [23:0] i_timeout    = 24'd20;
	logic [11:0] tgt          = 12'h600;
	logic [11:0] stp          = 12'hfff;
	logic        o_trig;
	logic [11:0] o_upper, o_lower, o_level, o_slew_dv;
	logic [23:0] o_slew_dt, o_transit;
	logic        o_half_busy;
	int          num_errors   = 0;
	int          cmp_count    = 0;
	int          c;
	int          total        = 0;
	stp_tb_row_t rows [14] = '{
		'{2'h0, 2'h0, 1'h0, 12'h600, 12'ha00, 12'h200, 1},
		'{2'h0, 2'h0, 1'h0, 12'ha00, 12'h600, 12'h200, 0},
		'{2'h0, 2'h1, 1'h0, 12'ha00, 12'h600, 12'h200, 1},
		'{2'h0, 2'h1, 1'h0, 12'h600, 12'ha00, 12'h200, 0},
		'{2'h0, 2'h2, 1'h0, 12'h600, 12'ha00, 12'h200, 1},
		'{2'h0, 2'h2, 1'h0, 12'ha00, 12'h600, 12'h200, 1},
		'{2'h0, 2'h0, 1'h1, 12'h600, 12'ha00, 12'h010, 1},
		'{2'h0, 2'h0, 1'h0, 12'h600, 12'ha00, 12'h010, 0},
		'{2'h0, 2'h0, 1'h1, 12'h600, 12'ha00, 12'h200, 0},
		'{2'h1, 2'h0, 1'h0, 12'ha00, 12'ha00, 12'h001, 1},
		'{2'h1, 2'h1, 1'h0, 12'ha00, 12'ha00, 12'h001, 0},
		'{2'h1, 2'h1, 1'h0, 12'h600, 12'h600, 12'h001, 1},
		'{2'h1, 2'h2, 1'h0, 12'h600, 12'h600, 12'h001, 1},
		'{2'h1, 2'h2, 1'h0, 12'ha00, 12'ha00, 12'h001, 1}
	};
	always #5 i_clk_sys = ~i_clk_sys;
	stp_src_model u_src (.i_clk_sys(i_clk_sys), .i_sel(i_src_sel),
		.i_target(tgt), .i_step(stp), .o_ch_data(i_ch_data));
	stp_trig uut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
		.i_ch_data(i_ch_data), .i_src_sel(i_src_sel), .i_class(i_class),
		.i_pol(i_pol), .i_slower(i_slower), .i_upper_wr(i_upper_wr),
		.i_upper_val(i_upper_val), .i_lower_wr(i_lower_wr),
		.i_lower_val(i_lower_val), .i_level_wr(i_level_wr),
		.i_level_val(i_level_val), .i_preset(i_preset),
		.i_half_req(i_half_req), .i_delta_time(i_delta_time),
		.i_timeout(i_timeout), .o_trig(o_trig), .o_upper(o_upper),
		.o_lower(o_lower), .o_level(o_level), .o_slew_dv(o_slew_dv),
		.o_slew_dt(o_slew_dt), .o_transit(o_transit),
		.o_half_busy(o_half_busy));
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			#1;
		end
	endtask
	task automatic watch(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			tick(1);
			if (o_trig === 1'b1)
				cnt++;
		end
	endtask
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		// an unknown result must count as a mismatch
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_rst;
		chk(o_upper === 12'h900 && o_lower === 12'h700, "reset thresholds");
		chk(o_level === 12'h800 && o_slew_dv === 12'h200, "reset level");
		chk(o_trig === 1'b0 && o_half_busy === 1'b0, "reset flags");
	endtask
	////////////////////////////////////////
	initial begin
		tick(8);
		chk_rst();
		tick(8);
		i_nrst = 1'b1;
		tick(1);
		for (int k = 0; k < 14; k++) begin
			i_class   = 2'h3;
			i_src_sel = k[1:0];
			tgt       = rows[k].st;
			stp       = 12'hfff;
			tick(10);
			i_pol     = rows[k].pol;
			i_slower  = rows[k].slw;
			i_class   = rows[k].cls;
			tick(5);
			tgt       = rows[k].tg;
			stp       = rows[k].sp;
			watch(100, c);
			chk(c == rows[k].n, "trigger count of table row");
			if (k == 6)
				// leaves at 12'h710, meets 12'h900 after 31 steps;
				// the count starts the cycle after leaving
				chk(o_transit === 24'd30, "transit");
		end
		// crossings every 15 cycles must never reach a 20 cycle timeout
		i_pol = 2'h0;
		stp   = 12'hfff;
		repeat (8) begin
			tgt = (tgt == 12'ha00) ? 12'h600 : 12'ha00;
			watch(15, c);
			total += c;
		end
		chk(total == 0, "timeout fired across crossings");
		i_timeout = 24'd30;
		watch(10, c);
		chk(c == 0, "timeout fired early");
		watch(40, c);
		chk(c == 1, "timeout missing");
		i_class  = 2'h3;
		i_preset = 2'h1;
		tick(2);
		chk(o_upper === 12'h8c0 && o_lower === 12'h840, "ttl preset");
		chk(o_level === stp_pkg::TTL_LEVEL, "ttl level");
		i_preset = 2'h2;
		tick(2);
		chk(o_upper === 12'h780 && o_lower === 12'h700, "ecl preset");
		chk(o_level === stp_pkg::ECL_LEVEL, "ecl level");
		i_preset   = 2'h0;
		i_upper_wr = 1'b1;
		i_lower_wr = 1'b1;
		i_level_wr = 1'b1;
		tick(1);
		i_upper_wr = 1'b0;
		i_lower_wr = 1'b0;
		i_level_wr = 1'b0;
		i_delta_time = 24'd40;
		tick(1);
		chk(o_level === 12'h7f0 && o_slew_dv === 12'h300, "writes");
		chk(o_slew_dt === 24'd40, "slew delta time");
		tgt = 12'h300;
		tick(5);
		i_half_req = 1'b1;
		tick(1);
		i_half_req = 1'b0;
		tick(2);
		chk(o_half_busy === 1'b1, "search not started");
		tgt = 12'hb00;
		c   = 0;
		while (o_half_busy !== 1'b0 && c < 1200) begin
			tick(1);
			c++;
		end
		chk(c < 1200 && o_level === 12'h700, "half level");
		// a hung search skips straight to the verdict
		if (c < 1200) begin
			i_nrst = 1'b0;
			tick(2);
			chk_rst();
			i_nrst = 1'b1;
			tick(2);
		end
		give_verdict();
	end
endmodule
